/* File: hw/app_regs.svh */
// Purpose: Register map, field positions and timing figures of the post-processing path
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by bare name
`ifndef APP_REGS_SVH
`define APP_REGS_SVH
// Register byte addresses
`define APP_ADDR_CTRL 12'h000
`define APP_ADDR_GAIN 12'h004
`define APP_ADDR_DCTC 12'h008
`define APP_ADDR_STAT 12'h00C
`define APP_ADDR_DCEST 12'h010
// Control register bit positions
`define APP_CTRL_BYPD 0
`define APP_CTRL_DCEN 1
`define APP_CTRL_HOLD 2
`define APP_CTRL_SLEEP 3
// Status register bit positions
`define APP_STAT_BYP 0
`define APP_STAT_VALID 1
`define APP_STAT_SLEEP 2
// Field widths and resets
`define APP_CODE_W 4
`define APP_CODE_RST 4'h0
// Latency in sampling clocks, bypass and processed
`define APP_BYP_LAT 10
`define APP_PROC_LAT 13
// Largest gain code, 12 half-decibel steps is 6 dB
`define APP_GAIN_MAX 4'hC
// Gain coefficient fraction bits, unity is 1 shifted by this
`define APP_GAIN_FRAC 14
// Largest time constant code, reserved codes above it
`define APP_TC_MAX 4'hB
// Code 0 is 2^20 cycles
`define APP_TC_BASE 20
// Ten millivolts in LSBs of a 2 Vpp, 14-bit range
`define APP_DC_MAX 82
// Wake-up time after sleep, and clock period
`define APP_WAKE_NS 100000
`define APP_CLK_NS 8
`endif

/* File: hw/app_pkg.sv */
// Purpose: Types shared by the post-processing path
// Assumes: Samples are twos complement
// Notes: No constants here, see app_regs.svh
package app_pkg;
    // Converter sample
    typedef logic signed [13:0] app_smp_t;
    // Four-bit control code
    typedef logic [3:0] app_code_t;
    // Power state, one-hot
    typedef enum logic [2:0] {
        APP_RUN = 3'b001,
        APP_SLEEP = 3'b010,
        APP_WAKE = 3'b100
    } app_pwr_t;
endpackage

/* File: hw/app_dc_if.sv */
// Purpose: Carrier between the sample path and the offset loop
// Assumes: Single clock domain
// Notes: Top drives controls and sample, loop returns estimate
`timescale 1ns/1ps
interface app_dc_if;
    app_pkg::app_smp_t smp; // Raw sample into the estimator
    logic en; // Correction enabled
    logic hold; // Estimate frozen
    app_pkg::app_code_t tc; // Time constant code
    app_pkg::app_smp_t est; // Current estimate
    modport top (output smp, output en, output hold, output tc, input est);
    modport loop (input smp, input en, input hold, input tc, output est);
endinterface

/* File: hw/app_dcloop.sv */
// Purpose: DC offset estimator, first order loop with power-of-two time constant
// Assumes: Controls come from registers on the same clock
// Notes: Estimate limited to the cancellable range, with anti-windup
`timescale 1ns/1ps
`include "app_regs.svh"
module app_dcloop (
    input wire logic clk,
    input wire logic rst,
    app_dc_if.loop dc
);
    ////////////////////////////////////////////////////////////////////////////
    // Accumulator holds estimate scaled by 2^shift
    logic signed [47:0] acc_q, acc_d;
    logic [5:0] shift_q, shift_d; // Active shift
    app_pkg::app_smp_t est_q, est_d;
    logic signed [47:0] diff; // Sample minus estimate, widened
    logic at_hi, at_lo; // Estimate pinned at a limit

    // Limit a wide value to the cancellable range
    function automatic app_pkg::app_smp_t app_lim(input logic signed [47:0] v);
        if (v > 48'sd`APP_DC_MAX) begin
            app_lim = 14'sd`APP_DC_MAX;
        end else if (v < -48'sd`APP_DC_MAX) begin
            app_lim = -14'sd`APP_DC_MAX;
        end else begin
            app_lim = v[13:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next loop state
    always_comb begin
        // Reserved codes act as the slowest legal one
        shift_d = (dc.tc > `APP_TC_MAX) ? 6'(`APP_TC_MAX) : 6'(dc.tc);
        shift_d = shift_d + 6'(`APP_TC_BASE);
        diff = 48'(dc.smp) - 48'(est_q);
        at_hi = (est_q == 14'sd`APP_DC_MAX) && (diff > 48'sd0);
        at_lo = (est_q == -14'sd`APP_DC_MAX) && (diff < 48'sd0);
        acc_d = acc_q;
        if (!dc.en) begin
            // Restart from zero when re-enabled
            acc_d = '0;
        end else if (!dc.hold && !at_hi && !at_lo) begin
            // Update every cycle; windup stops at the limits
            acc_d = acc_q + diff;
        end
        // Held estimate is kept as is, so a time constant change cannot move it
        if (!dc.en) begin
            est_d = '0;
        end else if (dc.hold) begin
            est_d = est_q;
        end else begin
            est_d = app_lim(acc_q >>> shift_q);
        end
    end

    // Register loop state
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= '0;
            shift_q <= 6'(`APP_TC_BASE);
            est_q <= '0;
        end else begin
            acc_q <= acc_d;
            shift_q <= shift_d;
            est_q <= est_d;
        end
    end

    assign dc.est = est_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_DC_LIM: assert property (@(posedge clk) disable iff (rst)
        (est_q <= 14'sd`APP_DC_MAX) && (est_q >= -14'sd`APP_DC_MAX))
        else $error("Offset estimate outside range");
    AST_DC_CLR: assert property (@(posedge clk) disable iff (rst)
        !dc.en |=> (acc_q == '0) ##1 (est_q == '0))
        else $error("Estimate not cleared when disabled");
    AST_DC_HOLD: assert property (@(posedge clk) disable iff (rst)
        (dc.en && dc.hold)[*3] |-> $stable(est_q) && $stable(acc_q))
        else $error("Estimate moved while held");
    AST_DC_SHIFT: assert property (@(posedge clk) disable iff (rst)
        (shift_q >= 6'(`APP_TC_BASE)) && (shift_q <= 6'(`APP_TC_BASE + `APP_TC_MAX)))
        else $error("Loop time constant out of range");
endmodule

/* File: hw/app_top.sv */
// Purpose: Post-processing path behind the converter core with APB control
// Assumes: Samples arrive on clk; APB on the same clock
// Notes: Summary of operation
//
// Summary of operation
// - Bypass outputs raw samples after ten clocks
// - Processing adds pipeline clocks over bypass
// - Bypass after reset; host sets bypass_disable
// - Gain zero to six dB, half steps
// - Bypass_disable enables gain at zero dB
// - Gain scales full-scale range, 0 dB default
// - Correction estimates and subtracts every cycle
// - Loop cancels up to ten millivolts offset
// - Time constant code doubles from 1M cycles
// - Hold freezes estimate, keeps applying it
// - Correction off at reset, needs its own enable bit and bypass_disable
// - Sleep powers down, outputs go high-impedance
// - Data valid about 100 us after wake
`timescale 1ns/1ps
`include "app_regs.svh"
module app_top #(
    parameter int WAKE_CYC = `APP_WAKE_NS / `APP_CLK_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [13:0] adc_in,
    output logic signed [13:0] data_out,
    output logic data_oe,
    output logic data_valid
);
    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic byp_dis_q, byp_dis_d; // Processing path selected
    logic dc_en_q, dc_en_d; // Offset correction on
    logic hold_q, hold_d; // Estimate frozen
    logic sleep_q, sleep_d; // Full chip sleep
    app_pkg::app_code_t gain_q, gain_d; // Half-decibel gain code
    app_pkg::app_code_t tc_q, tc_d; // Loop time constant code
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic wr_en; // Write completes this edge
    logic setup; // APB setup phase

    // Pipeline state
    app_pkg::app_smp_t line_q [`APP_BYP_LAT-1];
    app_pkg::app_smp_t line_d [`APP_BYP_LAT-1];
    app_pkg::app_smp_t corr_q, corr_d; // After offset subtraction
    logic signed [30:0] prod_q, prod_d; // After gain multiply
    app_pkg::app_smp_t sat_q, sat_d; // After rounding
    app_pkg::app_smp_t out_q, out_d;
    logic oe_q, oe_d;
    logic valid_q, valid_d;

    // Power state
    app_pkg::app_pwr_t pwr_q, pwr_d;
    logic [$clog2(WAKE_CYC+1)-1:0] wake_q, wake_d;

    app_dc_if dcb ();

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Mapped register test, used by the error answer only
    function automatic logic app_hit(input logic [11:0] a);
        app_hit = (a == `APP_ADDR_CTRL) || (a == `APP_ADDR_GAIN) || (a == `APP_ADDR_DCTC)
            || (a == `APP_ADDR_STAT) || (a == `APP_ADDR_DCEST);
    endfunction

    // Gain coefficient, unity = 2^14, steps of 0.5 dB
    function automatic logic [15:0] app_coef(input app_pkg::app_code_t g);
        unique case (g)
            4'h0: app_coef = 16'h4000;
            4'h1: app_coef = 16'h43CB;
            4'h2: app_coef = 16'h47CF;
            4'h3: app_coef = 16'h4C10;
            4'h4: app_coef = 16'h5092;
            4'h5: app_coef = 16'h5558;
            4'h6: app_coef = 16'h5A67;
            4'h7: app_coef = 16'h5FC2;
            4'h8: app_coef = 16'h656F;
            4'h9: app_coef = 16'h6B71;
            4'hA: app_coef = 16'h71CF;
            4'hB: app_coef = 16'h788E;
            // Codes past 6 dB stay at 6 dB
            default: app_coef = 16'h7FB2;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states, answer computed in setup
    always_comb begin
        setup = psel && !penable;
        wr_en = psel && penable && pready_q && pwrite;
        byp_dis_d = byp_dis_q;
        dc_en_d = dc_en_q;
        hold_d = hold_q;
        sleep_d = sleep_q;
        gain_d = gain_q;
        tc_d = tc_q;
        if (wr_en && (paddr == `APP_ADDR_CTRL)) begin
            byp_dis_d = pwdata[`APP_CTRL_BYPD];
            dc_en_d = pwdata[`APP_CTRL_DCEN];
            hold_d = pwdata[`APP_CTRL_HOLD];
            sleep_d = pwdata[`APP_CTRL_SLEEP];
        end
        if (wr_en && (paddr == `APP_ADDR_GAIN)) begin
            gain_d = pwdata[`APP_CODE_W-1:0];
        end
        if (wr_en && (paddr == `APP_ADDR_DCTC)) begin
            tc_d = pwdata[`APP_CODE_W-1:0];
        end
        // Ready rises for exactly the access phase
        pready_d = setup;
        pslverr_d = setup && !app_hit(paddr);
        prdata_d = '0;
        if (setup && !pwrite) begin
            unique case (paddr)
                `APP_ADDR_CTRL: begin
                    prdata_d[`APP_CTRL_BYPD] = byp_dis_q;
                    prdata_d[`APP_CTRL_DCEN] = dc_en_q;
                    prdata_d[`APP_CTRL_HOLD] = hold_q;
                    prdata_d[`APP_CTRL_SLEEP] = sleep_q;
                end
                `APP_ADDR_GAIN: prdata_d[`APP_CODE_W-1:0] = gain_q;
                `APP_ADDR_DCTC: prdata_d[`APP_CODE_W-1:0] = tc_q;
                `APP_ADDR_STAT: begin
                    prdata_d[`APP_STAT_BYP] = !byp_dis_q;
                    prdata_d[`APP_STAT_VALID] = valid_q;
                    prdata_d[`APP_STAT_SLEEP] = (pwr_q != app_pkg::APP_RUN);
                end
                `APP_ADDR_DCEST: prdata_d = 32'(dcb.est);
                // Unmapped reads return zero
                default: prdata_d = '0;
            endcase
        end
    end

    // Register APB and control state
    always_ff @(posedge clk) begin
        if (rst) begin
            // Bypass on, correction off, 0 dB
            byp_dis_q <= 1'b0;
            dc_en_q <= 1'b0;
            hold_q <= 1'b0;
            sleep_q <= 1'b0;
            gain_q <= `APP_CODE_RST;
            tc_q <= `APP_CODE_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            byp_dis_q <= byp_dis_d;
            dc_en_q <= dc_en_d;
            hold_q <= hold_d;
            sleep_q <= sleep_d;
            gain_q <= gain_d;
            tc_q <= tc_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset loop, only live when processing is selected
    assign dcb.smp = line_q[`APP_BYP_LAT-2];
    assign dcb.en = dc_en_q && byp_dis_q;
    assign dcb.hold = hold_q;
    assign dcb.tc = tc_q;

    app_dcloop u_dcloop (
        .clk(clk),
        .rst(rst),
        .dc(dcb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sample pipeline; sleep flushes it since the core is off
    always_comb begin
        logic signed [30:0] rnd;
        rnd = '0;
        line_d[0] = (pwr_q == app_pkg::APP_RUN) ? adc_in : '0;
        for (int i = 1; i < `APP_BYP_LAT - 1; i++) begin
            line_d[i] = (pwr_q == app_pkg::APP_RUN) ? line_q[i-1] : '0;
        end
        // Subtract estimate every cycle, zero when disabled
        corr_d = line_q[`APP_BYP_LAT-2] - dcb.est;
        // Gain applied after correction; code 0 is unity
        prod_d = 31'(corr_q) * 31'($signed({1'b0, app_coef(gain_q)}));
        // Round to nearest, then limit to the sample range
        rnd = prod_q + (31'sd1 <<< (`APP_GAIN_FRAC - 1));
        rnd = rnd >>> `APP_GAIN_FRAC;
        if (rnd > 31'sd8191) begin
            sat_d = 14'sh1FFF;
        end else if (rnd < -31'sd8192) begin
            sat_d = -14'sh2000;
        end else begin
            sat_d = rnd[13:0];
        end
        // Bypass taps the raw line; processing costs three more clocks
        if (pwr_q != app_pkg::APP_RUN) begin
            out_d = '0;
        end else if (!byp_dis_q) begin
            out_d = line_q[`APP_BYP_LAT-2];
        end else begin
            out_d = sat_q;
        end
    end

    // Register the pipeline
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `APP_BYP_LAT - 1; i++) begin
                line_q[i] <= '0;
            end
            corr_q <= '0;
            prod_q <= '0;
            sat_q <= '0;
            out_q <= '0;
        end else begin
            line_q <= line_d;
            corr_q <= corr_d;
            prod_q <= prod_d;
            sat_q <= sat_d;
            out_q <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state; wake time counted before data is called valid
    always_comb begin
        pwr_d = pwr_q;
        wake_d = wake_q;
        unique case (pwr_q)
            app_pkg::APP_RUN: begin
                if (sleep_q) begin
                    pwr_d = app_pkg::APP_SLEEP;
                end
            end
            app_pkg::APP_SLEEP: begin
                wake_d = '0;
                if (!sleep_q) begin
                    pwr_d = app_pkg::APP_WAKE;
                end
            end
            app_pkg::APP_WAKE: begin
                wake_d = wake_q + 1'b1;
                if (sleep_q) begin
                    pwr_d = app_pkg::APP_SLEEP;
                end else if (wake_q == ($bits(wake_q))'(WAKE_CYC - 1)) begin
                    pwr_d = app_pkg::APP_RUN;
                end
            end
            default: pwr_d = app_pkg::APP_SLEEP;
        endcase
        // Outputs released while asleep
        oe_d = !sleep_q && (pwr_d != app_pkg::APP_SLEEP);
        valid_d = (pwr_d == app_pkg::APP_RUN) && !sleep_q;
    end

    // Register the power state
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_q <= app_pkg::APP_RUN;
            wake_q <= '0;
            oe_q <= 1'b1;
            valid_q <= 1'b1;
        end else begin
            pwr_q <= pwr_d;
            wake_q <= wake_d;
            oe_q <= oe_d;
            valid_q <= valid_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign data_out = out_q;
    assign data_oe = oe_q;
    assign data_valid = valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks; counters track how long a mode has been steady
    logic [4:0] byp_run_q, proc_run_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            byp_run_q <= '0;
            proc_run_q <= '0;
        end else begin
            byp_run_q <= (!byp_dis_q && valid_q) ? byp_run_q + (byp_run_q != 5'h1F) : '0;
            proc_run_q <= (byp_dis_q && !dc_en_q && gain_q == `APP_CODE_RST && valid_q)
                ? proc_run_q + (proc_run_q != 5'h1F) : '0;
        end
    end

    AST_BYP_LAT: assert property (@(posedge clk) disable iff (rst)
        (byp_run_q > 5'(`APP_BYP_LAT)) |-> (data_out == $past(adc_in, `APP_BYP_LAT)))
        else $error("Bypass latency wrong");
    AST_PROC_LAT: assert property (@(posedge clk) disable iff (rst)
        (proc_run_q > 5'(`APP_PROC_LAT)) |-> (data_out == $past(adc_in, `APP_PROC_LAT)))
        else $error("Processed 0 dB latency or value wrong");
    AST_RST_STATE: assert property (@(posedge clk)
        rst |=> !byp_dis_q && !dc_en_q && (gain_q == `APP_CODE_RST) && !sleep_q)
        else $error("Reset state not bypass, 0 dB, correction off");
    AST_GAIN_COEF: assert property (@(posedge clk) disable iff (rst)
        (app_coef(gain_q) >= 16'h4000) && (app_coef(gain_q) <= 16'h7FB2))
        else $error("Gain outside 0 to 6 dB");
    AST_DC_ON: assert property (@(posedge clk) disable iff (rst)
        !byp_dis_q |=> (dcb.est == '0))
        else $error("Correction active in bypass");
    AST_SLEEP_OE: assert property (@(posedge clk) disable iff (rst)
        sleep_q |=> !data_oe && !data_valid && (data_out == '0))
        else $error("Outputs driven during sleep");
    AST_WAKE_WAIT: assert property (@(posedge clk) disable iff (rst)
        $fell(sleep_q) |-> !data_valid [*8])
        else $error("Data valid too soon after wake");

    COV_BYP: cover property (@(posedge clk) disable iff (rst) byp_run_q == 5'h1F);
    COV_PROC: cover property (@(posedge clk) disable iff (rst) proc_run_q == 5'h1F);
    COV_WAKE: cover property (@(posedge clk) disable iff (rst)
        (pwr_q == app_pkg::APP_WAKE) ##1 (pwr_q == app_pkg::APP_RUN));
endmodule

/* File: dv/app_rx_model.sv */
// Purpose: Receiving logic device that captures output samples of the path
// Assumes: Same sampling clock as the path, pins sampled on the rising edge
// Notes: Samples are discarded while the pins float or before data turns valid
`timescale 1ns/1ps
module app_rx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic signed [13:0] pins,
    input wire logic pins_oe,
    input wire logic pins_valid,
    output logic signed [13:0] rx_last,
    output logic [31:0] rx_count
);
    ////////////////////////////////////////////////////////////////////////////////
    // Capture only driven and valid samples, wake-up garbage must not count
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_last <= 14'sh0000;
            rx_count <= 32'h00000000;
        end else if (pins_oe && pins_valid) begin
            rx_last <= pins;
            rx_count <= rx_count + 32'h00000001;
        end
    end
endmodule

/* File: dv/adc_post_processing_path_tb_top.sv */
// Purpose: Self-checking bench for the post-processing path over APB
// Assumes: One clock, synchronous active high reset, one-cycle APB answer
// Notes: Wake count shortened to keep the run brief
`timescale 1ns/1ps
`include "app_regs.svh"
module adc_post_processing_path_tb_top;
    localparam int WAKE = 20; // Shortened wake-up count
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [13:0] adc_in = 14'sh0000;
    logic signed [13:0] adc_lvl = 14'sh0000; // Steady level used while not ramping
    logic signed [13:0] data_out;
    logic data_oe;
    logic data_valid;
    logic signed [13:0] pin_lvl; // Level seen on the pins, inverse of the last capture when released
    logic signed [13:0] rx_last;
    logic [31:0] rx_count;
    logic ramp = 1'b0; // Ramp stimulus makes latency visible as a constant gap
    int fails = 0;
    int check_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    app_top #(.WAKE_CYC(WAKE)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_in(adc_in), .data_out(data_out), .data_oe(data_oe),
        .data_valid(data_valid));
    // Released pins show the inverse of the last value, never a lucky match
    assign pin_lvl = data_oe ? data_out : ~rx_last;
    app_rx_model u_rx (.clk(clk), .rst(rst), .pins(pin_lvl), .pins_oe(data_oe),
        .pins_valid(data_valid), .rx_last(rx_last), .rx_count(rx_count));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and ramp source
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        // Only driver of the sample input, so steps land on the edge
        adc_in <= ramp ? adc_in + 14'sh0001 : adc_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    function automatic logic [31:0] z14(input logic [13:0] v);
        return {18'h0, v};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high at a rising edge
    task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) fails++;
    endtask
    task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb_xfer(a, 1'b1, d, r, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb_xfer(a, 1'b0, 32'h00000000, r, e);
        check(r, exp);
    endtask
    task automatic complete_run();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, run needs roughly 13400 cycles
    initial begin
        #(8 * 40000);
        fails++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        int ge;
        int gv;
        int n;
        logic [31:0] n0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`APP_ADDR_CTRL, 32'h00000000);
        rd_chk(`APP_ADDR_STAT, 32'h00000003);
        rd_chk(`APP_ADDR_GAIN, 32'h00000000);
        rd_chk(`APP_ADDR_DCEST, 32'h00000000);
        apb_xfer(12'h014, 1'b0, 32'h00000000, rd, er);
        check(rd, 32'h00000000);
        check({31'h0, er}, 32'h00000001);
        // Bypass gap, then processed gap
        ramp <= 1'b1;
        repeat (15) @(posedge clk);
        #1;
        check(z14(adc_in - data_out), 32'h0000000A);
        apb_wr(`APP_ADDR_CTRL, 32'h00000001);
        rd_chk(`APP_ADDR_STAT, 32'h00000002);
        repeat (20) @(posedge clk);
        #1;
        check(z14(adc_in - data_out), 32'h0000000D);
        @(posedge clk);
        ramp <= 1'b0;
        adc_lvl <= 14'sd1000;
        // Every gain code, reserved ones act as the top step
        for (int c = 0; c < 16; c++) begin
            apb_wr(`APP_ADDR_GAIN, c);
            repeat (16) @(posedge clk);
            #1;
            ge = $rtoi(1000.0 * 10.0 ** ((c > 12 ? 12.0 : c) / 40.0) + 0.5);
            gv = data_out;
            // One LSB of slack covers coefficient rounding
            check((gv - ge <= 1 && ge - gv <= 1) ? ge : gv, ge);
        end
        apb_wr(`APP_ADDR_GAIN, 32'h00000000);
        // Offset loop: slower constant gives a smaller estimate
        adc_lvl <= 14'sd8191;
        apb_wr(`APP_ADDR_DCTC, 32'h00000001);
        apb_wr(`APP_ADDR_CTRL, 32'h00000003);
        repeat (300) @(posedge clk);
        rd_chk(`APP_ADDR_DCEST, 32'h00000001);
        apb_wr(`APP_ADDR_CTRL, 32'h00000001);
        rd_chk(`APP_ADDR_DCEST, 32'h00000000);
        apb_wr(`APP_ADDR_DCTC, 32'h0000000F);
        rd_chk(`APP_ADDR_DCTC, 32'h0000000F);
        apb_wr(`APP_ADDR_DCTC, 32'h00000000);
        apb_wr(`APP_ADDR_CTRL, 32'h00000003);
        repeat (300) @(posedge clk);
        rd_chk(`APP_ADDR_DCEST, 32'h00000002);
        repeat (12000) @(posedge clk);
        rd_chk(`APP_ADDR_DCEST, 32'h00000052);
        #1;
        check(z14(data_out), z14(14'sd8109));
        check(z14(rx_last), z14(14'sd8109));
        // Hold keeps the estimate while the input moves
        apb_wr(`APP_ADDR_CTRL, 32'h00000007);
        adc_lvl <= 14'sd0;
        repeat (300) @(posedge clk);
        rd_chk(`APP_ADDR_DCEST, 32'h00000052);
        #1;
        check(z14(data_out), z14(-14'sd82));
        apb_wr(`APP_ADDR_CTRL, 32'h00000001);
        rd_chk(`APP_ADDR_DCEST, 32'h00000000);
        // Sleep and wake
        apb_wr(`APP_ADDR_CTRL, 32'h00000009);
        repeat (2) @(posedge clk);
        #1;
        check({30'h0, data_oe, data_valid}, 32'h00000000);
        check(z14(data_out), 32'h00000000);
        rd_chk(`APP_ADDR_STAT, 32'h00000004);
        n0 = rx_count;
        apb_wr(`APP_ADDR_CTRL, 32'h00000001);
        n = 0;
        while (data_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check((n >= WAKE - 2 && n <= WAKE + 6) ? 1 : 0, 32'h00000001);
        check(rx_count, n0);
        check({31'h0, data_oe}, 32'h00000001);
        complete_run();
    end
endmodule
